// ---- hw/ccr_pkg.sv ----
// Summary of operation
// - enable bit 6 powers comparator on; cleared switches it fully off.
// - while disabled the output status bit reads zero.
// - polarity bit 5 passes comparison straight (0) or inverted (1).
// - status bit 4 holds comparison result, meaning swapped by polarity.
// - two-bit response select, 00 slowest through 11 fastest, sent to analog.
// - control bits 7,1,0 and trim bit 7 read zero, writes ignored.
// - trim bit 6 selects normal (0) or offset calibration mode (1).
// - any change of the output status bit sets the interrupt flag.
package ccr_pkg;
  localparam int          NUM_CMP      = 2;
  // register word addresses
  localparam logic [3:0]  ADDR_CTRL0   = 4'h0;
  localparam logic [3:0]  ADDR_TRIM0   = 4'h1;
  localparam logic [3:0]  ADDR_CTRL1   = 4'h2;
  localparam logic [3:0]  ADDR_TRIM1   = 4'h3;
  localparam logic [3:0]  ADDR_INT_ST  = 4'h4;
  localparam logic [3:0]  ADDR_INT_MSK = 4'h5;
  // control register fields
  localparam int          CTRL_EN_BIT  = 6;
  localparam int          CTRL_POL_BIT = 5;
  localparam int          CTRL_OUT_BIT = 4;
  localparam int          CTRL_RSP_LSB = 2;
  localparam logic [7:0]  CTRL_WMASK   = 8'h6C;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  // offset trim register fields
  localparam int          TRIM_MODE_BIT = 6;
  localparam int          TRIM_REF_BIT  = 5;
  localparam logic [7:0]  TRIM_WMASK    = 8'h7F;
  localparam logic [7:0]  TRIM_RESET    = 8'h00;
  localparam logic [1:0]  INT_RESET     = 2'h0;

  // settings forwarded to one analog comparator
  typedef struct packed {
    logic       enable;
    logic [1:0] response_select;
    logic       calibration_mode;
    logic       calibration_reference_select;
    logic [4:0] offset_trim_code;
  } ccr_analog_s;
endpackage : ccr_pkg

// ---- hw/ccr_regs.sv ----
`timescale 1ns/1ns
module ccr_regs
(
  // clock and reset
  input  wire logic                     mclk_i,
  input  wire logic                     srst_i,
  // register port
  input  wire logic [3:0]               addr_i,
  input  wire logic [7:0]               wdata_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  output      logic [7:0]               rdata_o,
  // analog comparators
  input  wire logic [1:0]               cmp_raw_i,
  output      ccr_pkg::ccr_analog_s [1:0] analog_o,
  // interrupt
  output      logic                     irq_o
);
  logic [7:0] ctrl [2];
  logic [7:0] trim [2];
  logic [1:0] status;
  logic [1:0] status_q;
  logic [1:0] int_st;
  logic [1:0] int_msk;
  logic [1:0] cmp_change;
  logic [7:0] ctrl_rd [2];
  logic [7:0] next_rdata;

  genvar g;
  generate
    for (g = 0; g < ccr_pkg::NUM_CMP; g++)
    begin : g_cmp
      wire logic       wr_ctrl = wr_i && addr_i == (g ? ccr_pkg::ADDR_CTRL1 : ccr_pkg::ADDR_CTRL0);
      wire logic       wr_trim = wr_i && addr_i == (g ? ccr_pkg::ADDR_TRIM1 : ccr_pkg::ADDR_TRIM0);
      wire logic       en      = ctrl[g][ccr_pkg::CTRL_EN_BIT];
      // disabled forces zero; polarity inverts the raw comparison
      assign status[g] = en & (cmp_raw_i[g] ^ ctrl[g][ccr_pkg::CTRL_POL_BIT]);
      assign cmp_change[g] = status[g] ^ status_q[g];
      // read-only and unimplemented bits never stored
      assign ctrl_rd[g] = (ctrl[g] & ccr_pkg::CTRL_WMASK) | ({7'h00, status_q[g]} << ccr_pkg::CTRL_OUT_BIT);
      // settings to the analog side; enable low powers it down
      assign analog_o[g].enable = en;
      assign analog_o[g].response_select = ctrl[g][ccr_pkg::CTRL_RSP_LSB +: 2];
      assign analog_o[g].calibration_mode = trim[g][ccr_pkg::TRIM_MODE_BIT];
      assign analog_o[g].calibration_reference_select = trim[g][ccr_pkg::TRIM_REF_BIT];
      assign analog_o[g].offset_trim_code = trim[g][4:0];

      // register writes keep only implemented bits
      always_ff @(posedge mclk_i)
      begin
        if (srst_i)
        begin
          ctrl[g] <= ccr_pkg::CTRL_RESET;
          trim[g] <= ccr_pkg::TRIM_RESET;
        end
        else
        begin
          if (wr_ctrl)
            ctrl[g] <= wdata_i & ccr_pkg::CTRL_WMASK;
          if (wr_trim)
            trim[g] <= wdata_i & ccr_pkg::TRIM_WMASK;
        end
      end
    end
  endgenerate

  // read mux; unmapped addresses read zero
  always_comb
  begin
    unique case (addr_i)
      ccr_pkg::ADDR_CTRL0:   next_rdata = ctrl_rd[0];
      ccr_pkg::ADDR_TRIM0:   next_rdata = trim[0];
      ccr_pkg::ADDR_CTRL1:   next_rdata = ctrl_rd[1];
      ccr_pkg::ADDR_TRIM1:   next_rdata = trim[1];
      ccr_pkg::ADDR_INT_ST:  next_rdata = {6'h00, int_st};
      ccr_pkg::ADDR_INT_MSK: next_rdata = {6'h00, int_msk};
      default:               next_rdata = 8'h00;
    endcase
  end

  // status sampled, flags set-wins over write-one-to-clear
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      status_q <= 2'h0;
      int_st   <= ccr_pkg::INT_RESET;
      int_msk  <= ccr_pkg::INT_RESET;
      rdata_o  <= 8'h00;
    end
    else
    begin
      status_q <= status;
      int_st   <= (int_st & ~((wr_i && addr_i == ccr_pkg::ADDR_INT_ST) ? wdata_i[1:0] : 2'h0))
                  | cmp_change;
      if (wr_i && addr_i == ccr_pkg::ADDR_INT_MSK)
        int_msk <= wdata_i[1:0];
      rdata_o  <= rd_i ? next_rdata : 8'h00;
    end
  end

  assign irq_o = |(int_st & int_msk);

  // a change of the status bit raises the flag one edge later
  property p_change_sets_flag;
    @(posedge mclk_i) disable iff (srst_i)
      cmp_change[0] |=> int_st[0];
  endproperty
  a_change_sets_flag: assert property (p_change_sets_flag) else $error("change did not set flag");

  // disabled comparator reads zero status
  property p_disabled_zero;
    @(posedge mclk_i) disable iff (srst_i)
      !ctrl[1][ccr_pkg::CTRL_EN_BIT] |-> !status[1];
  endproperty
  a_disabled_zero: assert property (p_disabled_zero) else $error("disabled status not zero");

  // unimplemented control bits read zero
  property p_ctrl_reserved;
    @(posedge mclk_i) disable iff (srst_i)
      $past(rd_i) && $past(addr_i) == ccr_pkg::ADDR_CTRL0 |-> rdata_o[7] == 1'b0 && rdata_o[1:0] == 2'h0;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved) else $error("reserved control bits nonzero");

  // second comparator raises its own flag on a status change
  property p_change_sets_flag1;
    @(posedge mclk_i) disable iff (srst_i)
      cmp_change[1] |=> int_st[1];
  endproperty
  a_change_sets_flag1: assert property (p_change_sets_flag1) else $error("change did not set flag 1");

  // first comparator disabled reads zero status
  property p_disabled_zero0;
    @(posedge mclk_i) disable iff (srst_i)
      !ctrl[0][ccr_pkg::CTRL_EN_BIT] |-> !status[0];
  endproperty
  a_disabled_zero0: assert property (p_disabled_zero0) else $error("disabled status 0 not zero");

  // unimplemented control bits of the second comparator read zero
  property p_ctrl_reserved1;
    @(posedge mclk_i) disable iff (srst_i)
      $past(rd_i) && $past(addr_i) == ccr_pkg::ADDR_CTRL1 |-> rdata_o[7] == 1'h0 && rdata_o[1:0] == 2'h0;
  endproperty
  a_ctrl_reserved1: assert property (p_ctrl_reserved1) else $error("reserved control 1 bits nonzero");

  // top bit of either trim register reads zero
  property p_trim_reserved0;
    @(posedge mclk_i) disable iff (srst_i)
      $past(rd_i) && $past(addr_i) == ccr_pkg::ADDR_TRIM0 |-> rdata_o[7] == 1'h0;
  endproperty
  a_trim_reserved0: assert property (p_trim_reserved0) else $error("reserved trim 0 bit nonzero");

  property p_trim_reserved1;
    @(posedge mclk_i) disable iff (srst_i)
      $past(rd_i) && $past(addr_i) == ccr_pkg::ADDR_TRIM1 |-> rdata_o[7] == 1'h0;
  endproperty
  a_trim_reserved1: assert property (p_trim_reserved1) else $error("reserved trim 1 bit nonzero");

  // status bit read back shows the sampled comparison, one cycle behind the pin
  property p_status_read0;
    @(posedge mclk_i) disable iff (srst_i)
      $past(rd_i) && $past(addr_i) == ccr_pkg::ADDR_CTRL0 |-> rdata_o[ccr_pkg::CTRL_OUT_BIT] == $past(status_q[0]);
  endproperty
  a_status_read0: assert property (p_status_read0) else $error("status 0 read back wrong");

  property p_status_read1;
    @(posedge mclk_i) disable iff (srst_i)
      $past(rd_i) && $past(addr_i) == ccr_pkg::ADDR_CTRL1 |-> rdata_o[ccr_pkg::CTRL_OUT_BIT] == $past(status_q[1]);
  endproperty
  a_status_read1: assert property (p_status_read1) else $error("status 1 read back wrong");

  // addresses past the mask register answer with zero
  property p_unmapped_zero;
    @(posedge mclk_i) disable iff (srst_i)
      $past(rd_i) && $past(addr_i) > ccr_pkg::ADDR_INT_MSK |-> rdata_o == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read nonzero");

  // a control write never stores the reserved or read-only positions
  property p_ctrl_write_masked0;
    @(posedge mclk_i) disable iff (srst_i)
      wr_i && addr_i == ccr_pkg::ADDR_CTRL0 |=> ctrl[0][7] == 1'h0 && ctrl[0][4] == 1'h0 && ctrl[0][1:0] == 2'h0;
  endproperty
  a_ctrl_write_masked0: assert property (p_ctrl_write_masked0) else $error("control 0 stored reserved bits");

  // written enable and response select reach the analog side
  property p_ctrl_forward0;
    @(posedge mclk_i) disable iff (srst_i)
      wr_i && addr_i == ccr_pkg::ADDR_CTRL0 |=> analog_o[0].enable == $past(wdata_i[6])
        && analog_o[0].response_select == $past(wdata_i[3:2]);
  endproperty
  a_ctrl_forward0: assert property (p_ctrl_forward0) else $error("control 0 not forwarded");

  property p_ctrl_forward1;
    @(posedge mclk_i) disable iff (srst_i)
      wr_i && addr_i == ccr_pkg::ADDR_CTRL1 |=> analog_o[1].enable == $past(wdata_i[6])
        && analog_o[1].response_select == $past(wdata_i[3:2]);
  endproperty
  a_ctrl_forward1: assert property (p_ctrl_forward1) else $error("control 1 not forwarded");

  // calibration mode, reference and trim code reach the analog side
  property p_trim_forward0;
    @(posedge mclk_i) disable iff (srst_i)
      wr_i && addr_i == ccr_pkg::ADDR_TRIM0 |=> analog_o[0].calibration_mode == $past(wdata_i[6])
        && analog_o[0].calibration_reference_select == $past(wdata_i[5])
        && analog_o[0].offset_trim_code == $past(wdata_i[4:0]);
  endproperty
  a_trim_forward0: assert property (p_trim_forward0) else $error("trim 0 not forwarded");

  property p_trim_forward1;
    @(posedge mclk_i) disable iff (srst_i)
      wr_i && addr_i == ccr_pkg::ADDR_TRIM1 |=> analog_o[1].calibration_mode == $past(wdata_i[6])
        && analog_o[1].calibration_reference_select == $past(wdata_i[5])
        && analog_o[1].offset_trim_code == $past(wdata_i[4:0]);
  endproperty
  a_trim_forward1: assert property (p_trim_forward1) else $error("trim 1 not forwarded");

  // enabled with polarity clear the status follows the raw comparison
  property p_polarity_straight0;
    @(posedge mclk_i) disable iff (srst_i)
      ctrl[0][ccr_pkg::CTRL_EN_BIT] && !ctrl[0][ccr_pkg::CTRL_POL_BIT] |-> status[0] == cmp_raw_i[0];
  endproperty
  a_polarity_straight0: assert property (p_polarity_straight0) else $error("status 0 not straight");

  // enabled with polarity set the status is the inverse
  property p_polarity_invert0;
    @(posedge mclk_i) disable iff (srst_i)
      ctrl[0][ccr_pkg::CTRL_EN_BIT] && ctrl[0][ccr_pkg::CTRL_POL_BIT] |-> status[0] == !cmp_raw_i[0];
  endproperty
  a_polarity_invert0: assert property (p_polarity_invert0) else $error("status 0 not inverted");

  property p_polarity_straight1;
    @(posedge mclk_i) disable iff (srst_i)
      ctrl[1][ccr_pkg::CTRL_EN_BIT] && !ctrl[1][ccr_pkg::CTRL_POL_BIT] |-> status[1] == cmp_raw_i[1];
  endproperty
  a_polarity_straight1: assert property (p_polarity_straight1) else $error("status 1 not straight");

  property p_polarity_invert1;
    @(posedge mclk_i) disable iff (srst_i)
      ctrl[1][ccr_pkg::CTRL_EN_BIT] && ctrl[1][ccr_pkg::CTRL_POL_BIT] |-> status[1] == !cmp_raw_i[1];
  endproperty
  a_polarity_invert1: assert property (p_polarity_invert1) else $error("status 1 not inverted");

  // a flag stays set until software writes a one to it
  property p_flag_sticky0;
    @(posedge mclk_i) disable iff (srst_i)
      int_st[0] && !(wr_i && addr_i == ccr_pkg::ADDR_INT_ST && wdata_i[0]) |=> int_st[0];
  endproperty
  a_flag_sticky0: assert property (p_flag_sticky0) else $error("flag 0 dropped by itself");

  // a clear with no coincident change empties the flag
  property p_flag_clear0;
    @(posedge mclk_i) disable iff (srst_i)
      wr_i && addr_i == ccr_pkg::ADDR_INT_ST && wdata_i[0] && !cmp_change[0] |=> !int_st[0];
  endproperty
  a_flag_clear0: assert property (p_flag_clear0) else $error("flag 0 not cleared");

  // with every source masked the interrupt line stays low
  property p_irq_masked;
    @(posedge mclk_i) disable iff (srst_i)
      int_msk == 2'h0 |-> !irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt with all masked");
endmodule : ccr_regs

// ---- verif/ccr_regs_bench.sv ----
`timescale 1ns/1ns
module ccr_regs_bench;
  logic                       mclk_i = 1'b0;
  logic                       srst_i = 1'b1;
  logic [3:0]                 addr_i = 4'h0;
  logic [7:0]                 wdata_i = 8'h00;
  logic                       wr_i = 1'b0;
  logic                       rd_i = 1'b0;
  logic [1:0]                 cmp_raw_i = 2'h0;
  logic [7:0]                 rdata_o;
  ccr_pkg::ccr_analog_s [1:0] analog_o;
  logic                       irq_o;
  logic                       rd_pend = 1'b0;
  logic [8:0]                 notes[$];
  logic [7:0]                 ctl[2];
  logic [7:0]                 trm[2];
  logic [1:0]                 st = 2'h0;
  logic [1:0]                 flag = 2'h0;
  logic [1:0]                 msk = 2'h0;
  logic [7:0]                 d;
  logic                       r;
  int                         n;
  int                         err_count = 0;
  int                         check_count = 0;
  always #25 mclk_i = ~mclk_i;
  ccr_regs DUT (.mclk_i, .srst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .cmp_raw_i, .analog_o, .irq_o);
  task chk(input logic [9:0] got, input logic [9:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one cycle per access; a read notes the expected data and irq level
  task bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    {addr_i, wdata_i, wr_i, rd_i} <= {a, v, w, ~w};
    if (!w)
      notes.push_back({|(flag & msk), v});
  endtask : bus
  task idle(input int k);
    repeat (k) @(posedge mclk_i) {wr_i, rd_i} <= 2'b00;
  endtask : idle
  task test_done;
    $display("errors=%0d checks=%0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // read data stand one cycle only, so compare mid-cycle after the strobe
  always @(posedge mclk_i) rd_pend <= rd_i;
  always @(negedge mclk_i)
  begin
    if (rd_pend)
      chk({1'b0, irq_o, rdata_o}, notes.size() ? {1'b0, notes.pop_front()} : 10'h3FF);
  end
  // raw input moves on the edge where the control write lands, so status flips at most once
  initial
  begin
    void'($urandom(73));
    repeat (12) @(posedge mclk_i);
    srst_i <= 1'b0;
    for (int a = 0; a < 16; a++) bus(1'b0, 4'(a), 8'h00);
    for (int i = 0; i < 300; i++)
    begin
      n = $urandom_range(1, 0);
      d = $urandom;
      r = $urandom;
      bus(1'b1, {2'b00, n[0], 1'b0}, d);
      ctl[n] = d & ccr_pkg::CTRL_WMASK;
      d = $urandom;
      bus(1'b1, {2'b00, n[0], 1'b1}, d);
      cmp_raw_i[n] <= r;
      trm[n] = d & ccr_pkg::TRIM_WMASK;
      d[0] = ctl[n][6] & (r ^ ctl[n][5]);
      flag[n] = flag[n] | (d[0] ^ st[n]);
      st[n] = d[0];
      idle(3);
      #1 chk(analog_o[n], {ctl[n][6], ctl[n][3:2], trm[n][6:0]});
      bus(1'b0, {2'b00, n[0], 1'b0}, ctl[n] | {3'b000, st[n], 4'h0});
      bus(1'b0, {2'b00, n[0], 1'b1}, trm[n]);
      bus(1'b0, 4'h4, {6'h00, flag});
      bus(1'b0, 4'h5, {6'h00, msk});
      bus(1'b0, 4'(6 + $urandom_range(9, 0)), 8'h00);
      d = $urandom;
      bus(1'b1, 4'h4, d);
      flag = flag & ~d[1:0];
      d = $urandom;
      bus(1'b1, 4'h5, d);
      msk = d[1:0];
    end
    // calibration sweep: trim up on one comparator, down on the other
    for (int c = 0; c < 32; c++)
    begin
      bus(1'b1, 4'h1, 8'h60 | 8'(c));
      bus(1'b0, 4'h1, 8'h60 | 8'(c));
      bus(1'b1, 4'h3, 8'h7F - 8'(c));
      bus(1'b0, 4'h3, 8'h7F - 8'(c));
    end
    idle(2);
    if (notes.size() != 0)
      err_count++;
    test_done;
  end
endmodule : ccr_regs_bench
